// ===== spd_top.sv
// spd_top.sv: powerdown mode control, line validity and register port
`timescale 1ns/100ps
`include "spd_cfg.svh"

module spd_top #(
	parameter int unsigned INACT_CYC = `SPD_INACT_CYC
) (
	// clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        reset,
	// register port
	input  wire spd_pkg::spd_bus_req_s       bus_req,
	output logic      [`SPD_DATA_W-1:0]      bus_rdata,
	// force pins
	input  wire logic                        force_awake,
	input  wire logic                        force_sleep,
	// transmitter side
	input  wire logic [`SPD_NUM_TX-1:0]      tx_in,
	output logic      [`SPD_NUM_TX-1:0]      tx_out,
	output logic      [`SPD_NUM_TX-1:0]      tx_oe,
	// receiver side
	input  wire logic [`SPD_NUM_RX-1:0]      rx_in,
	input  wire logic [`SPD_NUM_RX-1:0]      rx_level_ok,
	input  wire logic                        monitor_in,
	output logic      [`SPD_NUM_RX-1:0]      rx_out,
	output logic      [`SPD_NUM_RX-1:0]      rx_oe,
	output logic                             monitor_receiver_out,
	// status pins
	output logic                             line_valid,
	output logic                             charge_pump_en
);

	import spd_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0]             frc_lvl, frc_chg;
	logic [`SPD_NUM_TX-1:0] tx_s, tx_chg;
	logic [`SPD_NUM_RX-1:0] rx_s, rx_chg, ok_s;
	logic                   mon_s;
	logic                   fa_s, fs_s;

	spd_sync #(.W(2), .RST(`SPD_FORCE_RST)) u_sync_frc (
		.sys_clk (sys_clk),
		.reset   (reset),
		.pin_in  ({force_awake, force_sleep}),
		.level   (frc_lvl),
		.change  (frc_chg)
	);
	spd_sync #(.W(`SPD_NUM_TX)) u_sync_tx (
		.sys_clk (sys_clk),
		.reset   (reset),
		.pin_in  (tx_in),
		.level   (tx_s),
		.change  (tx_chg)
	);
	spd_sync #(.W(`SPD_NUM_RX)) u_sync_rx (
		.sys_clk (sys_clk),
		.reset   (reset),
		.pin_in  (rx_in),
		.level   (rx_s),
		.change  (rx_chg)
	);
	spd_sync #(.W(`SPD_NUM_RX)) u_sync_ok (
		.sys_clk (sys_clk),
		.reset   (reset),
		.pin_in  (rx_level_ok),
		.level   (ok_s),
		.change  ()
	);
	spd_sync #(.W(1)) u_sync_mon (
		.sys_clk (sys_clk),
		.reset   (reset),
		.pin_in  (monitor_in),
		.level   (mon_s),
		.change  ()
	);

	assign fa_s = frc_lvl[1];
	assign fs_s = frc_lvl[0];

	// ----------------------------------------
	// register port
	// ----------------------------------------
	logic                   kick_reg, kick_next;
	logic [`SPD_DATA_W-1:0] rdata_reg, rdata_next;
	spd_status_s            status;

	always_comb begin
		kick_next  = bus_req.wr && (bus_req.addr == `SPD_ADDR_CTRL) && bus_req.wdata[`SPD_CTRL_KICK];
		rdata_next = '0;
		if (bus_req.rd && bus_req.addr == `SPD_ADDR_STATUS)
			rdata_next = status;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			kick_reg  <= 1'b0;
			rdata_reg <= '0;
		end else begin
			kick_reg  <= kick_next;
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// inactivity timer
	// ----------------------------------------
	logic      activity, auto_en, expired, fs_fall, tx_ready;
	spd_mode_e mode_reg, mode_next;

	// software kick counts as line activity
	assign activity = (|tx_chg) | (|rx_chg) | kick_reg;
	assign auto_en  = !fa_s && fs_s;
	assign fs_fall  = frc_chg[0] && !fs_s;

	// force_awake high or any edge restarts the 30 s period
	// manual entry with force_awake low leaves the timer expired
	spd_timer #(.W(`SPD_INACT_W), .TERM(INACT_CYC[`SPD_INACT_W-1:0])) u_inact (
		.sys_clk (sys_clk),
		.reset   (reset),
		.clear   (fa_s || activity),
		.preset  (fs_fall),
		.run     (auto_en),
		.done    (expired)
	);

	// ----------------------------------------
	// mode selection
	// ----------------------------------------
	always_comb begin
		if (!fs_s)
			mode_next = SPD_MODE_MANUAL;
		else if (fa_s)
			mode_next = SPD_MODE_NORMAL;
		// quiet for 30 s shuts down
		// an edge during manual powerdown clears expiry too
		// stays down after force_sleep rises until an edge
		else if (expired)
			mode_next = SPD_MODE_AUTO;
		else
			mode_next = SPD_MODE_NORMAL;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			mode_reg <= SPD_MODE_NORMAL;
		else
			mode_reg <= mode_next;
	end

	// ----------------------------------------
	// wake delay
	// ----------------------------------------
	// transmitters resume 100 us after wake
	spd_timer #(.W(`SPD_WAKE_W), .TERM(`SPD_WAKE_W'(`SPD_WAKE_CYC))) u_wake (
		.sys_clk (sys_clk),
		.reset   (reset),
		.clear   (mode_reg != SPD_MODE_NORMAL),
		.preset  (1'b0),
		.run     (1'b1),
		.done    (tx_ready)
	);

	// ----------------------------------------
	// line validity detector
	// ----------------------------------------
	logic all_inv, inv_done, val_done;
	logic lv_reg, lv_next;

	assign all_inv = ~|ok_s;

	// 30 us of invalid levels on every receiver
	spd_timer #(.W(`SPD_INVALID_W), .TERM(`SPD_INVALID_W'(`SPD_INVALID_CYC))) u_inv (
		.sys_clk (sys_clk),
		.reset   (reset),
		.clear   (!(lv_reg && all_inv)),
		.preset  (1'b0),
		.run     (1'b1),
		.done    (inv_done)
	);
	// 1 us of any valid level
	spd_timer #(.W(`SPD_VALID_W), .TERM(`SPD_VALID_W'(`SPD_VALID_CYC))) u_val (
		.sys_clk (sys_clk),
		.reset   (reset),
		.clear   (lv_reg || all_inv),
		.preset  (1'b0),
		.run     (1'b1),
		.done    (val_done)
	);

	always_comb begin
		lv_next = lv_reg;
		if (lv_reg && inv_done)
			lv_next = 1'b0;
		else if (!lv_reg && val_done)
			lv_next = 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			lv_reg <= 1'b1;
		else
			lv_reg <= lv_next;
	end

	// ----------------------------------------
	// output stage
	// ----------------------------------------
	logic [`SPD_NUM_TX-1:0] txo_reg, txo_next, txe_reg, txe_next;
	logic [`SPD_NUM_RX-1:0] rxo_reg, rxo_next, rxe_reg, rxe_next;
	logic                   mon_reg, mon_next, cp_reg, cp_next;

	always_comb begin
		// drivers and receivers invert the line
		txo_next = ~tx_s;
		rxo_next = ~rx_s;
		// drivers only once supplies have settled
		txe_next = {`SPD_NUM_TX{tx_ready && mode_reg == SPD_MODE_NORMAL}};
		rxe_next = {`SPD_NUM_RX{mode_reg != SPD_MODE_MANUAL}};
		mon_next = mon_s;
		cp_next  = (mode_reg == SPD_MODE_NORMAL);
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			txo_reg <= '0;
			txe_reg <= '0;
			rxo_reg <= '0;
			rxe_reg <= '0;
			mon_reg <= 1'b0;
			cp_reg  <= 1'b0;
		end else begin
			txo_reg <= txo_next;
			txe_reg <= txe_next;
			rxo_reg <= rxo_next;
			rxe_reg <= rxe_next;
			mon_reg <= mon_next;
			cp_reg  <= cp_next;
		end
	end

	always_comb begin
		status             = '0;
		status.force_sleep = fs_s;
		status.force_awake = fa_s;
		status.expired     = expired;
		status.tx_ready    = tx_ready;
		status.line_valid  = lv_reg;
		status.mode        = mode_reg;
	end

	assign tx_out               = txo_reg;
	assign tx_oe                = txe_reg;
	assign rx_out               = rxo_reg;
	assign rx_oe                = rxe_reg;
	assign monitor_receiver_out = mon_reg;
	assign charge_pump_en       = cp_reg;
	assign line_valid           = lv_reg;
	assign bus_rdata            = rdata_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	localparam int WAKE_MAX  = `SPD_WAKE_CYC + 2;
	localparam int INV_MAX   = `SPD_INVALID_CYC + 2;
	localparam int VAL_MAX   = `SPD_VALID_CYC + 2;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// long waits are counted, a wide delay range unrolls too slowly
	logic [`SPD_WAKE_W:0] wwait_reg, wwait_next, iwait_reg, iwait_next;
	always_comb begin
		wwait_next = (tx_oe[0] || mode_reg != SPD_MODE_NORMAL) ? '0 : wwait_reg + 1'b1;
		iwait_next = (lv_reg && all_inv) ? iwait_reg + 1'b1 : '0;
	end
	always_ff @(posedge sys_clk) begin
		wwait_reg <= reset ? '0 : wwait_next;
		iwait_reg <= reset ? '0 : iwait_next;
	end
	AST_SLEEP_WINS: assert property (!fs_s |=> mode_reg == SPD_MODE_MANUAL)
		else $error("force_sleep low did not give manual powerdown");
	AST_BOTH_HIGH: assert property (fa_s && fs_s |=> mode_reg == SPD_MODE_NORMAL)
		else $error("both force inputs high but not normal");
	AST_RX_OFF: assert property (!fs_s |=> ##1 rx_oe == '0)
		else $error("receivers active in manual powerdown");
	AST_TX_HIZ: assert property (mode_reg != SPD_MODE_NORMAL |=> tx_oe == '0)
		else $error("drivers enabled during powerdown");
	AST_WAKE: assert property (wwait_reg <= WAKE_MAX) else $error("wake took longer than allowed");
	AST_INVALID: assert property (iwait_reg <= INV_MAX) else $error("invalid lines not reported in time");
	AST_VALID: assert property (!lv_reg && !all_inv |-> ##[1:VAL_MAX] (lv_reg || all_inv))
		else $error("valid level not reported in time");
	AST_AUTO_WAKE: assert property (mode_reg == SPD_MODE_AUTO && activity && fs_s && !frc_chg[0] |=>
		##1 mode_reg != SPD_MODE_AUTO)
		else $error("edge did not leave automatic powerdown");
	AST_AUTO_WINDOW: assert property (mode_reg == SPD_MODE_AUTO |-> $past(!fa_s && fs_s))
		else $error("automatic powerdown outside its window");
	AST_EXP_HOLD: assert property (expired && !fa_s && !activity |=> expired)
		else $error("inactivity timer left expiry without cause");
	AST_MONITOR: assert property (!fs_s ##1 1'b1 |-> monitor_receiver_out == $past(mon_s))
		else $error("monitor receiver not following in powerdown");
	AST_AUTO_RX_ON: assert property (mode_reg == SPD_MODE_AUTO |=> rx_oe == '1)
		else $error("receivers disabled in automatic powerdown");

endmodule // spd_top

// ===== spd_cfg.svh
// spd_cfg.svh: constants of the serial port powerdown control
`ifndef SPD_CFG_SVH
`define SPD_CFG_SVH

// ----------------------------------------
// clock and times
// ----------------------------------------
`define SPD_CLK_MHZ      40
`define SPD_INACT_S      30
`define SPD_INVALID_US   30
`define SPD_VALID_US     1
`define SPD_WAKE_US      100
`define SPD_INACT_CYC    (`SPD_INACT_S * `SPD_CLK_MHZ * 1000000)
`define SPD_INVALID_CYC  (`SPD_INVALID_US * `SPD_CLK_MHZ)
`define SPD_VALID_CYC    (`SPD_VALID_US * `SPD_CLK_MHZ)
`define SPD_WAKE_CYC     (`SPD_WAKE_US * `SPD_CLK_MHZ)

// ----------------------------------------
// widths and channel counts
// ----------------------------------------
`define SPD_NUM_TX       3
`define SPD_NUM_RX       5
`define SPD_ADDR_W       4
`define SPD_DATA_W       8
`define SPD_INACT_W      31
`define SPD_INVALID_W    11
`define SPD_VALID_W      6
`define SPD_WAKE_W       12

// ----------------------------------------
// register map
// ----------------------------------------
`define SPD_ADDR_STATUS  4'h0
`define SPD_ADDR_CTRL    4'h4
`define SPD_CTRL_KICK    0
`define SPD_FORCE_RST    2'h3

`endif

// ===== spd_pkg.sv
// spd_pkg.sv: types of the serial port powerdown control
`include "spd_cfg.svh"

package spd_pkg;

	typedef enum logic [1:0] {
		SPD_MODE_NORMAL = 2'b00,
		SPD_MODE_AUTO   = 2'b01,
		SPD_MODE_MANUAL = 2'b10
	} spd_mode_e;

	typedef struct packed {
		logic [`SPD_ADDR_W-1:0] addr;
		logic [`SPD_DATA_W-1:0] wdata;
		logic                   wr;
		logic                   rd;
	} spd_bus_req_s;

	typedef struct packed {
		logic      force_sleep;
		logic      force_awake;
		logic      expired;
		logic      tx_ready;
		logic      line_valid;
		logic      pad;
		spd_mode_e mode;
	} spd_status_s;

endpackage

// ===== spd_sync.sv
// spd_sync.sv: three-stage pin synchroniser with edge detection
`timescale 1ns/100ps

module spd_sync #(
	parameter int unsigned W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         reset,
	// pins
	input  wire logic [W-1:0] pin_in,
	// settled level and change pulse
	output logic      [W-1:0] level,
	output logic      [W-1:0] change
);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_reg, s2_reg, s3_reg, lvl_reg, chg_reg;
			logic lvl_next, chg_next;
			// change counts only once the second and third stages agree
			always_comb begin
				lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
				chg_next = lvl_next ^ lvl_reg;
			end
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					s1_reg  <= RST[i];
					s2_reg  <= RST[i];
					s3_reg  <= RST[i];
					lvl_reg <= RST[i];
					chg_reg <= 1'b0;
				end else begin
					s1_reg  <= pin_in[i];
					s2_reg  <= s1_reg;
					s3_reg  <= s2_reg;
					lvl_reg <= lvl_next;
					chg_reg <= chg_next;
				end
			end
			assign level[i]  = lvl_reg;
			assign change[i] = chg_reg;
		end
	endgenerate

endmodule // spd_sync

// ===== spd_timer.sv
// spd_timer.sv: saturating interval counter
`timescale 1ns/100ps

module spd_timer #(
	parameter int unsigned  W    = 8,
	parameter logic [W-1:0] TERM = '1
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic reset,
	// control
	input  wire logic clear,
	input  wire logic preset,
	input  wire logic run,
	// terminal count reached
	output logic      done
);

	logic [W-1:0] cnt_reg, cnt_next;

	// clear beats preset so a fresh edge is never lost
	always_comb begin
		cnt_next = cnt_reg;
		if (clear)
			cnt_next = '0;
		else if (preset)
			cnt_next = TERM;
		else if (run && cnt_reg != TERM)
			cnt_next = cnt_reg + W'(1);
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	assign done = (cnt_reg == TERM);

endmodule // spd_timer

// ===== spd_host_model.sv
// spd_host_model.sv: host power logic that drives the force pins
`timescale 1ns/100ps

module spd_host_model (
	// scheme select and software commands
	input  wire logic [2:0] scheme,
	input  wire logic       cmd_awake,
	input  wire logic       cmd_sleep,
	// validity feedback
	input  wire logic       line_valid,
	// force pins
	output logic            force_awake,
	output logic            force_sleep
);
	// ----------------------------------------
	// pin drive per scheme
	// ----------------------------------------
	always_comb begin
		force_awake = 1'b1;
		force_sleep = 1'b1;
		case (scheme)
			3'h1: begin
				force_sleep = cmd_sleep;
			end
			3'h2: begin
				force_awake = cmd_awake;
				force_sleep = cmd_sleep;
			end
			3'h3: begin
				force_awake = line_valid;
				force_sleep = line_valid;
			end
			3'h4: begin
				force_awake = 1'b0;
				force_sleep = line_valid;
			end
			// strapped high, always on
			default: begin
			end
		endcase
	end
endmodule // spd_host_model

// ===== tb_top.sv
// tb_top.sv: self-checking bench of the powerdown control
`timescale 1ns/100ps
`include "spd_cfg.svh"

module tb_top;
	import spd_pkg::*;
	// short inactivity so auto powerdown is reachable
	localparam int INACT = 200;
	logic         sys_clk     = 1'b0;
	logic         reset       = 1'b1;
	spd_bus_req_s bus_req     = '0;
	logic [7:0]   bus_rdata;
	logic [7:0]   rd;
	logic         force_awake;
	logic         force_sleep;
	logic [2:0]   tx_in       = 3'h0;
	logic [2:0]   tx_out;
	logic [2:0]   tx_oe;
	logic [4:0]   rx_in       = 5'h00;
	logic [4:0]   rx_level_ok = 5'h1F;
	logic [4:0]   rx_out;
	logic [4:0]   rx_oe;
	logic         monitor_in  = 1'b0;
	logic         monitor_receiver_out;
	logic         line_valid;
	logic         charge_pump_en;
	logic [2:0]   scheme      = 3'h0;
	logic         cmd_awake   = 1'b1;
	logic         cmd_sleep   = 1'b1;
	int           err_total   = 0;
	int           num_checks  = 0;
	int           cyc         = 0;
	int           n;

	spd_top #(.INACT_CYC(INACT)) dut (.sys_clk(sys_clk), .reset(reset), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .force_awake(force_awake), .force_sleep(force_sleep), .tx_in(tx_in),
		.tx_out(tx_out), .tx_oe(tx_oe), .rx_in(rx_in), .rx_level_ok(rx_level_ok), .monitor_in(monitor_in),
		.rx_out(rx_out), .rx_oe(rx_oe), .monitor_receiver_out(monitor_receiver_out),
		.line_valid(line_valid), .charge_pump_en(charge_pump_en));
	spd_host_model host (.scheme(scheme), .cmd_awake(cmd_awake), .cmd_sleep(cmd_sleep),
		.line_valid(line_valid), .force_awake(force_awake), .force_sleep(force_sleep));

	always #12.5 sys_clk = ~sys_clk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// wait n edges, then let the edge updates land
	task automatic ws(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [3:0] a);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1;
		rd = bus_rdata;
	endtask
	task automatic chk_mode(input logic [1:0] m);
		bus_rd(`SPD_ADDR_STATUS);
		chk("mode", {6'h00, m}, {6'h00, rd[1:0]});
	endtask
	// bounded wait for all transmitters to drive
	task automatic wait_oe;
		n = 0;
		while (tx_oe !== 3'h7 && n < 5000) begin
			ws(1);
			n++;
		end
		chk("tx_oe", 8'h07, {5'h00, tx_oe});
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk("tx_oe", 8'h00, {5'h00, tx_oe});
		chk("line_valid", 8'h01, {7'h00, line_valid});
		@(posedge sys_clk) reset <= 1'b0;
		ws(8);
		bus_rd(`SPD_ADDR_STATUS);
		chk("status", 8'hC8, rd);
		bus_rd(4'h8);
		chk("unmapped", 8'h00, rd);
		bus_rd(`SPD_ADDR_CTRL);
		chk("ctrl", 8'h00, rd);
		$display("test reset done");
	endtask
	task automatic t_normal;
		wait_oe();
		@(posedge sys_clk) begin
			tx_in <= 3'h5;
			rx_in <= 5'h0A;
			monitor_in <= 1'b1;
		end
		ws(10);
		chk("tx_out", 8'h02, {5'h00, tx_out});
		chk("rx_out", 8'h15, {3'h0, rx_out});
		chk("monitor", 8'h01, {7'h00, monitor_receiver_out});
		ws(2 * INACT);
		bus_rd(`SPD_ADDR_STATUS);
		chk("status", 8'hD8, rd);
		chk("pump", 8'h01, {7'h00, charge_pump_en});
		$display("test normal done");
	endtask
	task automatic t_manual;
		@(posedge sys_clk) begin
			scheme <= 3'h1;
			cmd_sleep <= 1'b0;
			monitor_in <= 1'b0;
		end
		ws(12);
		chk("rx_oe", 8'h00, {3'h0, rx_oe});
		chk("tx_oe", 8'h00, {5'h00, tx_oe});
		chk("pump", 8'h00, {7'h00, charge_pump_en});
		chk("monitor", 8'h00, {7'h00, monitor_receiver_out});
		chk_mode(2'h2);
		@(posedge sys_clk) cmd_sleep <= 1'b1;
		ws(1);
		wait_oe();
		chk("wake time", 8'h01, {7'h00, n >= 3980 && n <= 4030});
		chk("rx_oe", 8'h1F, {3'h0, rx_oe});
		$display("test manual done");
	endtask
	task automatic t_awake_low;
		@(posedge sys_clk) begin
			scheme <= 3'h2;
			cmd_awake <= 1'b0;
			cmd_sleep <= 1'b0;
		end
		ws(12);
		chk_mode(2'h2);
		@(posedge sys_clk) cmd_sleep <= 1'b1;
		ws(12);
		chk_mode(2'h1);
		chk("expired", 8'h01, {7'h00, rd[5]});
		chk("tx_oe", 8'h00, {5'h00, tx_oe});
		@(posedge sys_clk) cmd_awake <= 1'b1;
		ws(12);
		chk_mode(2'h0);
		wait_oe();
		$display("test awake low done");
	endtask
	task automatic t_auto;
		@(posedge sys_clk) cmd_awake <= 1'b0;
		ws(INACT - 30);
		chk_mode(2'h0);
		ws(60);
		bus_rd(`SPD_ADDR_STATUS);
		chk("status", 8'h21, rd & 8'h23);
		chk("pump", 8'h00, {7'h00, charge_pump_en});
		chk("tx_oe", 8'h00, {5'h00, tx_oe});
		chk("rx_oe", 8'h1F, {3'h0, rx_oe});
		ws(INACT);
		chk_mode(2'h1);
		bus_wr(`SPD_ADDR_CTRL, 8'h01);
		ws(12);
		chk_mode(2'h0);
		ws(INACT - 60);
		@(posedge sys_clk) tx_in <= 3'h2;
		ws(INACT - 60);
		chk_mode(2'h0);
		ws(80);
		chk_mode(2'h1);
		@(posedge sys_clk) rx_in <= 5'h01;
		ws(12);
		chk_mode(2'h0);
		@(posedge sys_clk) cmd_awake <= 1'b1;
		wait_oe();
		$display("test auto done");
	endtask
	task automatic t_valid;
		@(posedge sys_clk) rx_level_ok <= 5'h00;
		ws(1190);
		chk("line_valid", 8'h01, {7'h00, line_valid});
		ws(30);
		chk("line_valid", 8'h00, {7'h00, line_valid});
		chk("pump", 8'h01, {7'h00, charge_pump_en});
		@(posedge sys_clk) rx_level_ok <= 5'h10;
		ws(30);
		chk("line_valid", 8'h00, {7'h00, line_valid});
		ws(25);
		chk("line_valid", 8'h01, {7'h00, line_valid});
		$display("test validity done");
	endtask
	task automatic t_hybrid;
		@(posedge sys_clk) begin
			scheme <= 3'h4;
			rx_level_ok <= 5'h00;
		end
		ws(1230);
		chk("line_valid", 8'h00, {7'h00, line_valid});
		chk("rx_oe", 8'h00, {3'h0, rx_oe});
		@(posedge sys_clk) rx_level_ok <= 5'h1F;
		ws(60);
		chk("line_valid", 8'h01, {7'h00, line_valid});
		chk_mode(2'h1);
		chk("tx_oe", 8'h00, {5'h00, tx_oe});
		@(posedge sys_clk) rx_in <= 5'h03;
		ws(12);
		chk_mode(2'h0);
		$display("test hybrid done");
	endtask
	// validity fed back to both force pins
	task automatic t_standard;
		@(posedge sys_clk) begin
			scheme <= 3'h3;
			rx_level_ok <= 5'h00;
		end
		ws(1230);
		chk("line_valid", 8'h00, {7'h00, line_valid});
		chk_mode(2'h2);
		@(posedge sys_clk) rx_level_ok <= 5'h1F;
		ws(60);
		chk_mode(2'h0);
		$display("test standard done");
	endtask

	// ----------------------------------------
	// verdict and run control
	// ----------------------------------------
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// whole run needs about 21000 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			summarize();
		end
	end
	initial begin
		ws(15);
		t_reset();
		t_normal();
		t_manual();
		t_awake_low();
		t_auto();
		t_valid();
		t_hybrid();
		t_standard();
		summarize();
	end
endmodule // tb_top
